// File: cmtf_defs.svh
// Offsets, field positions, reset values and widths of the CAN mode/timing/filter control block
`ifndef CMTF_DEFS_SVH
`define CMTF_DEFS_SVH
// Register byte offsets
`define CMTF_OFS_CONTROL    8'h00
`define CMTF_OFS_BIT_TIMING 8'h04
`define CMTF_OFS_INT_STAT   8'h08
`define CMTF_OFS_INT_MASK   8'h0c
`define CMTF_OFS_STAMP      8'h10
`define CMTF_OFS_FILTER0    8'h20
`define CMTF_OFS_FILTER1    8'h24
`define CMTF_OFS_FILTER2    8'h28
`define CMTF_OFS_FILTER3    8'h2c
// Control register fields
`define CMTF_ABORT_BIT      27
`define CMTF_REQ_LSB        24
`define CMTF_CUR_LSB        21
`define CMTF_CAP_BIT        20
`define CMTF_ON_BIT         15
`define CMTF_IDLE_BIT       13
`define CMTF_BUSY_BIT       11
// Bit timing register fields
`define CMTF_BRP_LSB        0
`define CMTF_SJW_LSB        6
`define CMTF_PRSEG_LSB      8
`define CMTF_PH1_LSB        11
`define CMTF_SAM_BIT        14
`define CMTF_FREE_BIT       15
`define CMTF_PH2_LSB        16
`define CMTF_CFG_WMASK      32'h0007_ffff
// Filter byte fields
`define CMTF_FSEL_LSB       0
`define CMTF_MSEL_LSB       5
`define CMTF_FEN_BIT        7
// Reset values and widths
`define CMTF_RST_REQ        3'h4
`define CMTF_RST_CFG        32'h0000_0000
`define CMTF_RST_FILTER     32'h0000_0000
`define CMTF_NUM_EVENTS     3
`define CMTF_STAMP_W        16
`endif

// File: cmtf_pkg.sv
// Types shared by the CAN mode/timing/filter control block
package cmtf_pkg;
    // Operating modes; 3'h5 and 3'h6 are reserved and never held
    typedef enum logic [2:0] {
        CMTF_NORMAL      = 3'h0,
        CMTF_DISABLE     = 3'h1,
        CMTF_LOOPBACK    = 3'h2,
        CMTF_LISTEN_ONLY = 3'h3,
        CMTF_CONFIG      = 3'h4,
        CMTF_LISTEN_ALL  = 3'h7
    } cmtf_mode_t;
endpackage

// File: cmtf_quantum_gen.sv
// Time quantum and bit time tick generator
`timescale 1ns/1ps
module cmtf_quantum_gen (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       run,            // Count only while the module is on
    input  wire logic [5:0] prescaler,      // Quantum prescaler field
    input  wire logic [4:0] quanta_per_bit, // Whole bit length in quanta
    output logic            tq_tick,        // One pulse per time quantum
    output logic            bit_tick        // One pulse per bit time
);
    logic [6:0] div_cnt_reg;  // System clocks within the quantum
    logic [4:0] tq_cnt_reg;   // Quanta within the bit
    wire  [6:0] div_limit;    // Last count of the quantum
    wire        div_wrap;
    wire        bit_wrap;

    // One quantum is 2*(prescaler+1) system clocks
    assign div_limit = {prescaler, 1'b1}; // R8
    assign div_wrap  = run && (div_cnt_reg == div_limit);
    assign bit_wrap  = div_wrap && (tq_cnt_reg == quanta_per_bit - 5'h01);

    ////////////////////////////////////////////////////////////////////
    // Quantum divider
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !run || div_wrap) begin
            div_cnt_reg <= 7'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
        end
    end

    // Quanta within the bit
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !run || bit_wrap) begin
            tq_cnt_reg <= 5'h00;
        end else if (div_wrap) begin
            tq_cnt_reg <= tq_cnt_reg + 5'h01;
        end
    end

    // Registered ticks
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            tq_tick  <= 1'b0;
            bit_tick <= 1'b0;
        end else begin
            tq_tick  <= div_wrap;
            bit_tick <= bit_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    logic [7:0] gap_reg; // Cycles since the last quantum tick
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !run) begin
            gap_reg <= 8'h00;                // Divider restarts from zero
        end else if (tq_tick) begin
            gap_reg <= 8'h01;
        end else if (gap_reg != 8'hff) begin
            gap_reg <= gap_reg + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    tq_period_a : assert property ( // R8
        tq_tick && $past(tq_tick, 1) == 1'b0 && $stable(prescaler) && run && $past(run)
        && gap_reg != 8'h01
        |-> gap_reg == {1'b0, div_limit} + 8'h01)
        else $error("Quantum period does not match the prescaler");
    tq_cover_c : cover property (bit_tick);
endmodule

// File: cmtf_ctrl.sv
// CAN mode, timing, abort, time stamp and filter control with register port
// How it works
// [R1] Requested mode field, eight codes, two reserved
// [R2] Current mode readable, same encoding
// [R3] Abort bit held until all aborts done
// [R4] Stamp captured on good receive; timer stops
// [R5] Disable finishes transaction; activity flag meanwhile
// [R6] Propagation length is field plus one
// [R7] Jump width is field plus one
// [R8] Quantum is two times prescaler plus one
// [R9] Phase 2 automatic unless free programming
// [R10] Software avoids three-sample with small prescaler
// [R11] Software keeps quanta per bit above seven
// [R12] Timing register writable in configuration only
// [R13] Per-filter enable bit gates matching
// [R14] Two-bit mask select picks one of four
// [R15] Five-bit field picks destination FIFO
// [R16] Mask and FIFO fields locked while enabled
// [R17] Four filters per register, byte each
// [R18] Reserved mode requests are ignored
// [R19] Current mode follows at bus idle only; the code also follows at once while the module is not active
`include "cmtf_defs.svh"
`timescale 1ns/1ps
module cmtf_ctrl (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    input  wire logic        bus_idle,        // Engine at a bus idle point
    input  wire logic        engine_busy,     // Engine inside a transaction
    input  wire logic        tx_abort_done,   // All transmit buffers have aborted
    input  wire logic        rx_msg_valid,    // Pulse on each valid received message
    output logic             abort_all_tx,
    output logic [2:0]       current_op_mode,
    output logic             module_activity_flag,
    output logic             idle_stop,
    output logic             rx_stamp_valid,
    output logic [15:0]      rx_stamp,
    output logic [3:0]       prop_segment_len,
    output logic [2:0]       resync_jump_width,
    output logic [3:0]       phase1_len,
    output logic [3:0]       phase2_len,
    output logic             three_sample,
    output logic             tq_tick,
    output logic             bit_tick,
    output logic [15:0]      filter_enable_n,
    output logic [31:0]      filter_mask_sel_n,
    output logic [79:0]      filter_fifo_sel_n
);
    ////////////////////////////////////////////////////////////////////
    // Functions

    // A length field counts one quantum more than its value
    function automatic logic [3:0] cmtf_len(input logic [2:0] f);
        cmtf_len = {1'b0, f} + 4'h1;
    endfunction

    // Codes 5 and 6 are reserved
    function automatic logic cmtf_mode_ok(input logic [2:0] m);
        cmtf_mode_ok = (m != 3'h5) && (m != 3'h6);
    endfunction

    // Filter write: enable always, other fields only while disabled
    function automatic logic [31:0] cmtf_flt_next(input logic [31:0] old,
                                                  input logic [31:0] wd);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            r[8*i+`CMTF_FEN_BIT] = wd[8*i+`CMTF_FEN_BIT];
            if (!old[8*i+`CMTF_FEN_BIT]) begin
                r[8*i +: 7] = wd[8*i +: 7];
            end
        end
        cmtf_flt_next = r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State
    logic [2:0]                  req_mode_reg;   // Requested mode
    cmtf_pkg::cmtf_mode_t        cur_mode_reg;   // Mode in force
    logic                        abort_reg;      // Abort all request
    logic                        cap_en_reg;     // Time stamp capture enable
    logic                        on_reg;         // Module enable from software
    logic                        idle_reg;       // Stop in idle
    logic                        active_reg;     // Module still running
    logic [31:0]                 cfg_reg;        // Bit timing register
    logic [31:0]                 flt_reg [4];    // Filter control registers
    logic [`CMTF_STAMP_W-1:0]    timer_reg;      // Receive time stamp timer
    logic [`CMTF_NUM_EVENTS-1:0] stat_reg;       // Sticky events
    logic [`CMTF_NUM_EVENTS-1:0] mask_reg;       // Interrupt mask

    ////////////////////////////////////////////////////////////////////
    // Decode
    wire wr_ctl   = reg_wr && (reg_addr == `CMTF_OFS_CONTROL);
    wire wr_cfg   = reg_wr && (reg_addr == `CMTF_OFS_BIT_TIMING);
    wire wr_mask  = reg_wr && (reg_addr == `CMTF_OFS_INT_MASK);
    wire rd_stat  = reg_rd && (reg_addr == `CMTF_OFS_INT_STAT);
    wire in_cfg   = (cur_mode_reg == cmtf_pkg::CMTF_CONFIG);
    wire [3:0] wr_flt;
    assign wr_flt[0] = reg_wr && (reg_addr == `CMTF_OFS_FILTER0);
    assign wr_flt[1] = reg_wr && (reg_addr == `CMTF_OFS_FILTER1);
    assign wr_flt[2] = reg_wr && (reg_addr == `CMTF_OFS_FILTER2);
    assign wr_flt[3] = reg_wr && (reg_addr == `CMTF_OFS_FILTER3);

    // Mode change may land at a bus idle point, or at once when stopped
    wire mode_step = (bus_idle || !active_reg)
                     && cmtf_mode_ok(req_mode_reg)                   // R18
                     && (req_mode_reg != cur_mode_reg);              // R19

    // Phase 2 follows phase 1 unless freely programmed
    wire [2:0] ph1_f = cfg_reg[`CMTF_PH1_LSB +: 3];
    wire [2:0] ph2_f = cfg_reg[`CMTF_FREE_BIT] ? cfg_reg[`CMTF_PH2_LSB +: 3]
                                               : ph1_f;              // R9
    wire [4:0] qpb   = 5'h01 + {1'b0, cmtf_len(cfg_reg[`CMTF_PRSEG_LSB +: 3])}
                     + {1'b0, cmtf_len(ph1_f)} + {1'b0, cmtf_len(ph2_f)};

    // Events: mode reached, abort complete, stamp captured
    wire ev_abort = abort_reg && tx_abort_done;
    wire ev_stamp = rx_msg_valid && cap_en_reg && active_reg;
    wire [`CMTF_NUM_EVENTS-1:0] ev = {ev_stamp, ev_abort, mode_step};
    wire [`CMTF_NUM_EVENTS-1:0] stat_next = (rd_stat ? '0 : stat_reg) | ev;

    // Read images
    wire [31:0] ctl_img = ({31'h0, abort_reg} << `CMTF_ABORT_BIT)
                        | ({29'h0, req_mode_reg} << `CMTF_REQ_LSB)
                        | ({29'h0, cur_mode_reg} << `CMTF_CUR_LSB)  // R2
                        | ({31'h0, cap_en_reg} << `CMTF_CAP_BIT)
                        | ({31'h0, on_reg} << `CMTF_ON_BIT)
                        | ({31'h0, idle_reg} << `CMTF_IDLE_BIT)
                        | ({31'h0, active_reg} << `CMTF_BUSY_BIT);
    logic [31:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            `CMTF_OFS_CONTROL:    rd_mux = ctl_img;
            `CMTF_OFS_BIT_TIMING: rd_mux = cfg_reg;
            `CMTF_OFS_INT_STAT:   rd_mux = {29'h0, stat_reg};
            `CMTF_OFS_INT_MASK:   rd_mux = {29'h0, mask_reg};
            `CMTF_OFS_STAMP:      rd_mux = {timer_reg, rx_stamp};
            `CMTF_OFS_FILTER0:    rd_mux = flt_reg[0];
            `CMTF_OFS_FILTER1:    rd_mux = flt_reg[1];
            `CMTF_OFS_FILTER2:    rd_mux = flt_reg[2];
            `CMTF_OFS_FILTER3:    rd_mux = flt_reg[3];
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Control register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            req_mode_reg <= `CMTF_RST_REQ;
            cap_en_reg   <= 1'b0;
            on_reg       <= 1'b0;
            idle_reg     <= 1'b0;
        end else if (wr_ctl) begin
            req_mode_reg <= reg_wdata[`CMTF_REQ_LSB +: 3];          // R1
            cap_en_reg   <= reg_wdata[`CMTF_CAP_BIT];
            on_reg       <= reg_wdata[`CMTF_ON_BIT];
            idle_reg     <= reg_wdata[`CMTF_IDLE_BIT];
        end
    end

    // Abort: software sets, hardware clears once all aborts are done
    always_ff @(posedge sys_clk) begin
        if (!rst_b || ev_abort) begin
            abort_reg <= 1'b0;                                       // R3
        end else if (wr_ctl && reg_wdata[`CMTF_ABORT_BIT]) begin
            abort_reg <= 1'b1;                                       // R3
        end
    end

    // Mode in force
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cur_mode_reg <= cmtf_pkg::CMTF_CONFIG;
        end else if (mode_step) begin
            cur_mode_reg <= cmtf_pkg::cmtf_mode_t'(req_mode_reg);   // R19
        end
    end

    // Stays active until the transaction in progress is over
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= on_reg || (active_reg && engine_busy);    // R5
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bit timing register, configuration mode only
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cfg_reg <= `CMTF_RST_CFG;
        end else if (wr_cfg && in_cfg) begin
            cfg_reg <= reg_wdata & `CMTF_CFG_WMASK;                  // R12
        end
    end

    // Decoded lengths
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prop_segment_len  <= 4'h1;
            resync_jump_width <= 3'h1;
            phase1_len        <= 4'h1;
            phase2_len        <= 4'h1;
            three_sample      <= 1'b0;
        end else begin
            prop_segment_len  <= cmtf_len(cfg_reg[`CMTF_PRSEG_LSB +: 3]);      // R6
            resync_jump_width <= {1'b0, cfg_reg[`CMTF_SJW_LSB +: 2]} + 3'h1; // R7
            phase1_len        <= cmtf_len(ph1_f);
            phase2_len        <= cmtf_len(ph2_f);                              // R9
            three_sample      <= cfg_reg[`CMTF_SAM_BIT];
        end
    end

    // Quantum and bit time ticks
    cmtf_quantum_gen u_qgen (
        .sys_clk        (sys_clk),
        .rst_b          (rst_b),
        .run            (active_reg),
        .prescaler      (cfg_reg[`CMTF_BRP_LSB +: 6]),                          // R8
        .quanta_per_bit (qpb),
        .tq_tick        (tq_tick),
        .bit_tick       (bit_tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Filter control registers
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!rst_b) begin
                flt_reg[i] <= `CMTF_RST_FILTER;
            end else if (wr_flt[i]) begin
                flt_reg[i] <= cmtf_flt_next(flt_reg[i], reg_wdata);   // R16
            end
        end
    end

    // Filter n sits in byte n mod 4 of register n div 4
    for (genvar n = 0; n < 16; n++) begin : g_flt
        assign filter_enable_n[n]         = flt_reg[n/4][8*(n%4)+`CMTF_FEN_BIT]; // R13 R17
        assign filter_mask_sel_n[2*n +: 2] = flt_reg[n/4][8*(n%4)+`CMTF_MSEL_LSB +: 2]; // R14
        assign filter_fifo_sel_n[5*n +: 5] = flt_reg[n/4][8*(n%4)+`CMTF_FSEL_LSB +: 5]; // R15
    end

    ////////////////////////////////////////////////////////////////////
    // Receive time stamp timer runs per bit time, halted without capture
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            timer_reg <= '0;
        end else if (cap_en_reg && bit_tick) begin
            timer_reg <= timer_reg + 16'h0001;                       // R4
        end
    end

    // Stamp taken with each valid message while capture is enabled and the module is active
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rx_stamp       <= '0;
            rx_stamp_valid <= 1'b0;
        end else begin
            rx_stamp_valid <= ev_stamp;
            if (ev_stamp) begin
                rx_stamp <= timer_reg;                               // R4
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupts: sticky status cleared by read, set wins
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            stat_reg <= '0;
            mask_reg <= '0;
            irq      <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            if (wr_mask) begin
                mask_reg <= reg_wdata[`CMTF_NUM_EVENTS-1:0];
            end
            irq <= |(stat_next & (wr_mask ? reg_wdata[`CMTF_NUM_EVENTS-1:0] : mask_reg));
        end
    end

    // Read data stand for one cycle only
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= rd_mux;
        end
    end

    // Registered copies of control state
    assign abort_all_tx         = abort_reg;
    assign current_op_mode      = cur_mode_reg;
    assign module_activity_flag = active_reg;
    assign idle_stop            = idle_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks
    logic chk_live_reg; // High once reset has been released for a whole cycle
    // Keeps history checks off the edge where reset lifts
    always_ff @(posedge sys_clk) begin
        chk_live_reg <= rst_b;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b || !chk_live_reg);

    reserved_mode_a : assert property (cmtf_mode_ok(current_op_mode)) // R18
        else $error("Current mode holds a reserved code");
    mode_lag_a : assert property ( // R19
        !$stable(current_op_mode) |-> $past(bus_idle || !active_reg)
        && current_op_mode == $past(req_mode_reg))
        else $error("Mode changed away from an idle point");
    cfg_lock_a : assert property ( // R12
        !$stable(cfg_reg) |-> $past(in_cfg) && $past(wr_cfg))
        else $error("Bit timing changed outside configuration mode");
    flt_lock_a : assert property ( // R16
        $past(filter_enable_n[13])
        |-> $stable(filter_mask_sel_n[27:26]) && $stable(filter_fifo_sel_n[69:65]))
        else $error("Locked filter fields changed");
    abort_clear_a : assert property ( // R3
        $fell(abort_all_tx) |-> $past(tx_abort_done))
        else $error("Abort cleared before the aborts were done");
    ts_stop_a : assert property ( // R4
        !cap_en_reg && $past(!cap_en_reg) |-> $stable(timer_reg))
        else $error("Time stamp timer ran with capture off");
    ts_capture_a : assert property ( // R4
        rx_msg_valid && cap_en_reg && active_reg
        |=> rx_stamp_valid && rx_stamp == $past(timer_reg))
        else $error("Time stamp not captured with the message");
    activity_hold_a : assert property ( // R5
        active_reg && engine_busy |=> module_activity_flag)
        else $error("Activity flag dropped inside a transaction");
    phase2_auto_a : assert property ( // R9
        !cfg_reg[`CMTF_FREE_BIT] |=> phase2_len == phase1_len)
        else $error("Automatic phase 2 differs from phase 1");
    prop_len_a : assert property ( // R6
        $stable(cfg_reg) |=> prop_segment_len == {1'b0, $past(cfg_reg[10:8])} + 4'h1)
        else $error("Propagation length is not field plus one");
    irq_a : assert property (
        (stat_reg & mask_reg) != '0 && !rd_stat && !wr_mask |=> irq)
        else $error("Unmasked event did not raise the interrupt");

    mode_cover_c  : cover property (mode_step ##[1:50] in_cfg);
    abort_cover_c : cover property ($fell(abort_all_tx));
    stamp_cover_c : cover property (rx_stamp_valid && irq);
endmodule

// File: cmtf_engine_model.sv
// Behavioural model of the CAN protocol engine beside the control block
`timescale 1ns/1ps
module cmtf_engine_model #(
    parameter int ABORT_DLY = 5      // Cycles the transmit buffers need to abort
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic abort_all_tx,
    input  wire logic hold_busy,     // Bench asks for a bus transaction
    input  wire logic rx_req,        // Bench asks for one received message
    output logic      bus_idle,
    output logic      engine_busy,
    output logic      tx_abort_done,
    output logic      rx_msg_valid
);
    logic [3:0] abort_cnt;           // Cycles the abort request has been seen
    ////////////////////////////////////////////////////////////////////////////////
    // Abort takes a while, so the control bit must wait for it
    always_ff @(posedge sys_clk) begin
        if (!rst_b || !abort_all_tx) begin
            abort_cnt <= 4'h0;
        end else if (abort_cnt != ABORT_DLY[3:0]) begin
            abort_cnt <= abort_cnt + 4'h1;
        end
    end
    assign tx_abort_done = abort_all_tx && (abort_cnt == ABORT_DLY[3:0]);
    assign engine_busy   = hold_busy;
    assign bus_idle      = !hold_busy;
    assign rx_msg_valid  = rx_req;
endmodule

// File: can_mode_timing_filter_ctrl_bench.sv
// Self-checking bench for the CAN mode, timing and filter control block
`include "cmtf_defs.svh"
`timescale 1ns/1ps
module can_mode_timing_filter_ctrl_bench;
    localparam logic [7:0] a_ctl = `CMTF_OFS_CONTROL;
    localparam logic [7:0] a_cfg = `CMTF_OFS_BIT_TIMING;
    localparam logic [7:0] a_stm = `CMTF_OFS_STAMP;
    logic        sys_clk, rst_b, reg_wr, reg_rd, irq, hold_busy, rx_req;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d0, d1;
    logic        bus_idle, engine_busy, tx_abort_done, rx_msg_valid, abort_all_tx;
    logic        module_activity_flag, rx_stamp_valid, three_sample, tq_tick, bit_tick, idle_stop;
    logic [2:0]  current_op_mode, resync_jump_width, prev;
    logic [3:0]  prop_segment_len, phase1_len, phase2_len;
    logic [15:0] rx_stamp, filter_enable_n;
    logic [31:0] filter_mask_sel_n;
    logic [79:0] filter_fifo_sel_n;
    logic [2:0]  modes [6] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4}; // Legal mode codes
    int          failures, checks_done, n;
    ////////////////////////////////////////////////////////////////////////////////
    cmtf_ctrl cmtf_ctrl_inst (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .bus_idle, .engine_busy, .tx_abort_done, .rx_msg_valid,
        .abort_all_tx, .current_op_mode, .module_activity_flag, .idle_stop,
        .rx_stamp_valid, .rx_stamp, .prop_segment_len, .resync_jump_width, .phase1_len,
        .phase2_len, .three_sample, .tq_tick, .bit_tick, .filter_enable_n,
        .filter_mask_sel_n, .filter_fifo_sel_n);
    cmtf_engine_model cmtf_engine_model_inst (.sys_clk, .rst_b, .abort_all_tx, .hold_busy,
        .rx_req, .bus_idle, .engine_busy, .tx_abort_done, .rx_msg_valid);
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe, then a quiet cycle
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk) #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge sys_clk) #1;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(a, d);
        check(d, exp);
    endtask
    task automatic wait_cyc(input int c);
        repeat (c) @(posedge sys_clk) #1;
    endtask
    // Align to a tick, then count clocks to the next one (bounded)
    task automatic gap(input bit use_bit, output int g);
        int k;
        k = 0;
        g = 1;
        while ((use_bit ? bit_tick : tq_tick) !== 1'b1 && k < 300) @(posedge sys_clk) #1 k++;
        @(posedge sys_clk) #1;
        while ((use_bit ? bit_tick : tq_tick) !== 1'b1 && g < 300) @(posedge sys_clk) #1 g++;
    endtask
    task automatic test_done();
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {rst_b, reg_wr, reg_rd, hold_busy, rx_req, reg_addr, reg_wdata} = '0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk) #1;
        chk_rd(a_ctl, 32'h0480_0000);
        chk_rd(8'h40, 32'h0000_0000);
        // Prescaler 2 and seventeen quanta per bit keep the software limits
        wr_reg(a_cfg, 32'hfffa_dfc2);
        chk_rd(a_cfg, 32'h0002_dfc2);
        check({prop_segment_len, resync_jump_width, phase1_len, phase2_len, three_sample},
              {4'h8, 3'h4, 4'h4, 4'h3, 1'b1});
        wr_reg(a_cfg, 32'h0002_5fc2);
        wait_cyc(1);
        check(phase2_len, 4'h4);
        wr_reg(a_ctl, 32'h0000_8000);
        wait_cyc(3);
        check(current_op_mode, 3'h0);
        gap(1'b0, n);
        check(n, 6);
        gap(1'b1, n);
        check(n, 102);
        wr_reg(a_cfg, 32'h0000_0000);
        chk_rd(a_cfg, 32'h0002_5fc2);
        wr_reg(a_ctl, 32'h0500_8000);
        wr_reg(a_ctl, 32'h0600_8000);
        wait_cyc(3);
        check(current_op_mode, 3'h0);
        prev = 3'h0;
        foreach (modes[i]) begin
            hold_busy <= 1'b1;
            wr_reg(a_ctl, {5'h0, modes[i], 24'h00_8000});
            wait_cyc(3);
            check(current_op_mode, prev);
            hold_busy <= 1'b0;
            wait_cyc(3);
            chk_rd(a_ctl, {5'h0, modes[i], modes[i], 21'h00_8800});
            prev = modes[i];
        end
        // Abort with its status bit unmasked
        rd_reg(`CMTF_OFS_INT_STAT, d0);
        wr_reg(`CMTF_OFS_INT_MASK, 32'h0000_0002);
        wr_reg(a_ctl, 32'h0c00_8000);
        chk_rd(a_ctl, 32'h0c80_8800);
        wait_cyc(8);
        check({abort_all_tx, irq}, 2'b01);
        chk_rd(`CMTF_OFS_INT_STAT, 32'h0000_0002);
        wait_cyc(1);
        check(irq, 1'b0);
        // Capture just after a bit tick so the timer holds still
        wr_reg(a_ctl, 32'h0410_8000);
        gap(1'b1, n);
        wait_cyc(1);
        rd_reg(a_stm, d0);
        rx_req <= 1'b1;
        @(posedge sys_clk);
        rx_req <= 1'b0;
        #1 check({rx_stamp_valid, rx_stamp}, {1'b1, d0[31:16]});
        @(posedge sys_clk) #1 check(irq, 1'b0);
        // Capture off: timer frozen, receptions not stamped
        wr_reg(a_ctl, 32'h0400_8000);
        rd_reg(a_stm, d0);
        wait_cyc(200);
        rd_reg(a_stm, d1);
        check(d1[31:16], d0[31:16]);
        rx_req <= 1'b1;
        @(posedge sys_clk);
        rx_req <= 1'b0;
        #1 check(rx_stamp_valid, 1'b0);
        // Switching off in mid-transaction
        hold_busy <= 1'b1;
        wr_reg(a_ctl, 32'h0400_2000);
        wait_cyc(4);
        check({module_activity_flag, idle_stop}, 2'b11);
        hold_busy <= 1'b0;
        wait_cyc(3);
        check(module_activity_flag, 1'b0);
        // Filters 13 and 12, then locked and unlocked field writes
        wr_reg(`CMTF_OFS_FILTER3, 32'h0000_e52a);
        check({filter_enable_n[13:12], filter_mask_sel_n[27:24], filter_fifo_sel_n[69:60]},
              {2'b10, 2'h3, 2'h1, 5'h05, 5'h0a});
        wr_reg(`CMTF_OFS_FILTER3, 32'h0000_9f2a);
        chk_rd(`CMTF_OFS_FILTER3, 32'h0000_e52a);
        wr_reg(`CMTF_OFS_FILTER3, 32'h0000_1f2a);
        chk_rd(`CMTF_OFS_FILTER3, 32'h0000_652a);
        wr_reg(`CMTF_OFS_FILTER3, 32'h0000_1f2a);
        chk_rd(`CMTF_OFS_FILTER3, 32'h0000_1f2a);
        test_done();
    end
endmodule
